// *** verilog/scg_defines.svh ***
// Constants of the system clock generator: port map, field positions, reset values, counts.
//
// Contract
// R1: Software selects processor clock low/high speed and DMA clock standard/high speed.
// R2: High-speed processor clock is taken from the high-speed oscillator input.
// R3: Low-speed clock follows low oscillator, or high oscillator divided by 2 if held.
// R4: Speed change is glitch-free, clock held high at most 1.5 new periods.
// R5: Standard DMA clock is processor clock /4 at low speed, /8 at high.
// R6: High-speed DMA clock runs at twice the standard frequency in both modes.
// R7: DMA clock changes frequency only on bus-state boundaries, no other synchronisation.
// R8: Coprocessor clock always equals low-speed source, unaffected by speed switching.
// R9: Expansion bus clock is processor clock /2 at low speed, /4 at high.
// R10: At high speed the bus clock phase realigns at the end of address latch.
// R11: Timer clock is the reference oscillator divided by 12.
// R12: Keyboard clock is reference divided by 2, with an exact complement output.
// R13: Writing one to bit 6 of port 063H enters sleep mode.
// R14: In sleep processor and DMA clocks stop high; bus clock stops with processor.
// R15: Each stops on its own first rising edge after hold acknowledge is seen.
// R16: Keyboard, timer and coprocessor clocks keep running during sleep.
// R17: External logic wakes the device by pulsing the reset request input low.
// R18: Wake pulse rising edge restarts stopped clocks glitch-free after about 2 keyboard periods.
// R19: A wake pulse during sleep never produces a processor reset.
// R20: Keyboard controller drives the reset request input during normal operation.
// R21: Speed selects and sleep request are writable bits, resetting low, standard, awake.
`ifndef SCG_DEFINES_SVH
`define SCG_DEFINES_SVH

`define SCG_CTRL_PORT 10'h063
`define SCG_CPU_SPEED_BIT 0
`define SCG_DMA_SPEED_BIT 1
`define SCG_SLEEP_BIT 6

`define SCG_CPU_HIGH_RST 1'b0
`define SCG_DMA_HIGH_RST 1'b0
`define SCG_SLEEP_RST 1'b0

`define SCG_CLK_MHZ 25
`define SCG_LO_IDLE_NS 640
`define SCG_LO_IDLE_CYCLES 5'((`SCG_LO_IDLE_NS * `SCG_CLK_MHZ) / 1000)

`define SCG_DMA_HALF_2 3'h1
`define SCG_DMA_HALF_4 3'h2
`define SCG_DMA_HALF_8 3'h4
`define SCG_BUS_HALF_LO 2'h1
`define SCG_BUS_HALF_HI 2'h2

`define SCG_TIMER_HALF 4'h6
`define SCG_KBD_HALF 4'h1
`define SCG_KBD_DIV 2
`define SCG_WAKE_KBD_PERIODS 2
`define SCG_WAKE_REF_EDGES 3'(`SCG_WAKE_KBD_PERIODS * `SCG_KBD_DIV)

`define SCG_SYNC_W 6

`endif

// *** verilog/scg_pkg.sv ***
// Types shared by the system clock generator modules.
package scg_pkg;

  typedef enum logic [3:0] {
    CK_RUN = 4'b0001,
    CK_HOLD = 4'b0010,
    CK_STOP = 4'b0100,
    CK_SPARE = 4'b1000
  } scg_cpu_st_t;

  typedef struct packed {
    logic [5:0] stage1;
    logic [5:0] stage2;
  } scg_sync_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic clk;
    logic clk_n;
  } scg_div_t;

  typedef struct packed {
    logic cpu_high;
    logic dma_high;
    logic sleep;
    scg_cpu_st_t cpu_st;
    logic cpu_clk;
    logic cpu_sel;
    logic src_prev;
    logic lo_prev;
    logic hs_prev;
    logic ref_prev;
    logic req_prev;
    logic ale_prev;
    logic [4:0] lo_idle;
    logic lo_dead;
    logic hs_div2;
    logic low_src;
    logic tphase;
    logic dma_clk;
    logic [2:0] dma_cnt;
    logic [2:0] dma_half;
    logic dma_frozen;
    logic bus_clk;
    logic [1:0] bus_cnt;
    logic hold_seen;
    logic waking;
    logic [2:0] wake_cnt;
    logic reset_mask;
    logic cpu_rst;
  } scg_top_t;

endpackage

// *** verilog/scg_sync.sv ***
// Two-stage synchroniser for the asynchronous pin inputs.
`timescale 1ns/1ns
`include "scg_defines.svh"

module scg_sync
  import scg_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [`SCG_SYNC_W-1:0] d_in,
  output logic [`SCG_SYNC_W-1:0] q_out
);

  scg_sync_t r;
  scg_sync_t n;

  // The first stage feeds only the second stage.
  always_comb begin
    n = r;
    n.stage1 = d_in;
    n.stage2 = r.stage1;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign q_out = r.stage2;

endmodule // scg_sync

// *** verilog/scg_div.sv ***
// Edge-counting clock divider with true and complement outputs.
`timescale 1ns/1ns
`include "scg_defines.svh"

module scg_div
  import scg_pkg::*;
#(
  parameter logic [3:0] HALF = 4'h1
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic edge_in,
  output logic clk_out,
  output logic clk_n_out
);

  scg_div_t r;
  scg_div_t n;
  logic [3:0] cnt_inc;

  // Output toggles after HALF source rising edges, so the ratio is 2*HALF.
  always_comb begin
    n = r;
    cnt_inc = r.cnt + 4'h1;
    if (edge_in) begin
      if (cnt_inc >= HALF) begin
        n.cnt = 4'h0;
        n.clk = ~r.clk;
        n.clk_n = r.clk;
      end else begin
        n.cnt = cnt_inc;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '{cnt: 4'h0, clk: 1'b0, clk_n: 1'b1};
    end else begin
      r <= n;
    end
  end

  assign clk_out = r.clk;
  assign clk_n_out = r.clk_n;

endmodule // scg_div

// *** verilog/scg_top.sv ***
// System clock generator: processor, DMA, bus, coprocessor, timer and keyboard clocks.
`timescale 1ns/1ns
`include "scg_defines.svh"

module scg_top
  import scg_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  input wire logic LOW_SPEED_OSC_IN,
  input wire logic HIGH_SPEED_OSC_IN,
  input wire logic REFERENCE_OSC_IN,
  input wire logic CPU_RESET_REQUEST_N_IN,
  input wire logic HOLD_ACKNOWLEDGE_IN,
  input wire logic ADDR_LATCH_EN_IN,
  input wire logic PORT_WR_IN,
  input wire logic [9:0] PORT_ADDR_IN,
  input wire logic [7:0] PORT_DATA_IN,
  output logic CPU_CLOCK_OUT,
  output logic DMA_CONTROLLER_CLOCK_OUT,
  output logic EXPANSION_BUS_CLOCK_OUT,
  output logic COPROCESSOR_CLOCK_OUT,
  output logic TIMER_CLOCK_OUT,
  output logic KBD_CLOCK_OUT,
  output logic KBD_CLOCK_N_OUT,
  output logic CPU_RESET_OUT,
  output logic SLEEP_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  scg_top_t r;
  scg_top_t n;

  logic [`SCG_SYNC_W-1:0] sy;
  logic lo;
  logic hs;
  logic refc;
  logic req_n;
  logic hold_acknowledge_in;
  logic ale;

  logic ref_rise;
  logic asleep;
  logic wake_done;
  logic old_src;
  logic new_src;
  logic cpu_rise;
  logic dma_tick;
  logic [2:0] dma_cnt_inc;
  logic [2:0] dma_sel_half;
  logic [1:0] bus_cnt_inc;
  logic [1:0] bus_half;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation.

  scg_sync u_sync (
    .clk_in(CLOCK_IN),
    .rst_in(RST_IN),
    .d_in({ADDR_LATCH_EN_IN, HOLD_ACKNOWLEDGE_IN, CPU_RESET_REQUEST_N_IN,
           REFERENCE_OSC_IN, HIGH_SPEED_OSC_IN, LOW_SPEED_OSC_IN}),
    .q_out(sy)
  );

  assign lo = sy[0];
  assign hs = sy[1];
  assign refc = sy[2];
  assign req_n = sy[3];
  assign hold_acknowledge_in = sy[4];
  assign ale = sy[5];

  assign ref_rise = refc & ~r.ref_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Reference-derived clocks; these never see the sleep logic.

  scg_div #(.HALF(`SCG_TIMER_HALF)) u_timer_div ( // R11 R16
    .clk_in(CLOCK_IN),
    .rst_in(RST_IN),
    .edge_in(ref_rise),
    .clk_out(TIMER_CLOCK_OUT),
    .clk_n_out()
  );

  scg_div #(.HALF(`SCG_KBD_HALF)) u_kbd_div ( // R12 R16
    .clk_in(CLOCK_IN),
    .rst_in(RST_IN),
    .edge_in(ref_rise),
    .clk_out(KBD_CLOCK_OUT),
    .clk_n_out(KBD_CLOCK_N_OUT)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    n = r;
    asleep = r.sleep | r.hold_seen | r.waking;
    wake_done = 1'b0;
    old_src = 1'b0;
    new_src = 1'b0;
    cpu_rise = 1'b0;
    dma_cnt_inc = r.dma_cnt + 3'h1;
    bus_cnt_inc = r.bus_cnt + 2'h1;
    bus_half = r.cpu_sel ? `SCG_BUS_HALF_HI : `SCG_BUS_HALF_LO; // R9

    n.lo_prev = lo;
    n.hs_prev = hs;
    n.ref_prev = refc;
    n.req_prev = req_n;
    n.ale_prev = ale;

    // A low oscillator held high with no transition for the idle window is taken as
    // strapped; the half-rate high oscillator then stands in for it.
    if (lo != r.lo_prev) begin
      n.lo_idle = 5'h00;
      n.lo_dead = 1'b0;
    end else if (r.lo_idle == `SCG_LO_IDLE_CYCLES) begin
      n.lo_dead = lo; // R3
    end else begin
      n.lo_idle = r.lo_idle + 5'h01;
    end
    if (hs & ~r.hs_prev) begin
      n.hs_div2 = ~r.hs_div2; // R3
    end
    n.low_src = r.lo_dead ? r.hs_div2 : lo; // R3 R8

    // Stop is armed once hold acknowledge is seen with sleep requested.
    if (r.sleep && hold_acknowledge_in && !r.waking) begin
      n.hold_seen = 1'b1; // R15
    end

    // Wake sequence runs on reference edges, so it keeps working while
    // the processor domain clocks are stopped.
    if (r.waking) begin
      if (ref_rise) begin
        n.wake_cnt = r.wake_cnt + 3'h1;
        if (n.wake_cnt == `SCG_WAKE_REF_EDGES) begin
          wake_done = 1'b1; // R18
          n.waking = 1'b0;
          n.sleep = 1'b0;
          n.hold_seen = 1'b0;
          n.dma_frozen = 1'b0;
        end
      end
    end else if ((r.sleep || r.hold_seen) && req_n && !r.req_prev) begin
      n.waking = 1'b1; // R18
      n.wake_cnt = 3'h0;
    end

    // Control port write; a sleep request written in the wake cycle wins.
    if (PORT_WR_IN && PORT_ADDR_IN == `SCG_CTRL_PORT) begin
      n.cpu_high = PORT_DATA_IN[`SCG_CPU_SPEED_BIT]; // R1 R21
      n.dma_high = PORT_DATA_IN[`SCG_DMA_SPEED_BIT]; // R1 R21
      if (PORT_DATA_IN[`SCG_SLEEP_BIT]) begin
        n.sleep = 1'b1; // R13
      end
    end

    // A request that begins while asleep is masked until it is released.
    n.reset_mask = ~req_n & (asleep | r.reset_mask); // R19
    n.cpu_rst = ~req_n & ~n.reset_mask; // R19

    //////////////////////////////////////////////////////////////////////////
    // Processor clock selection and stop.

    old_src = r.cpu_sel ? hs : r.low_src; // R2
    case (r.cpu_st)
      CK_RUN: begin
        n.cpu_clk = old_src;
        if (r.cpu_high != r.cpu_sel && old_src) begin
          // Switch only while high, then wait for the new source to fall.
          n.cpu_st = CK_HOLD; // R4
          n.cpu_sel = r.cpu_high;
          n.cpu_clk = 1'b1;
        end else if (r.hold_seen && old_src && !r.cpu_clk) begin
          n.cpu_st = CK_STOP; // R14 R15
        end
      end
      CK_HOLD: begin
        new_src = r.cpu_sel ? hs : r.low_src;
        n.cpu_clk = 1'b1;
        if (!new_src) begin
          n.cpu_st = CK_RUN; // R4
          n.cpu_clk = 1'b0;
        end
      end
      CK_STOP: begin
        n.cpu_clk = 1'b1; // R14
        if (wake_done) begin
          // Restart through the hold state so the first low is a clean one.
          n.cpu_st = CK_HOLD; // R18
          n.cpu_sel = r.cpu_high;
        end
      end
      default: begin
        n.cpu_st = CK_RUN;
        n.cpu_clk = 1'b1;
      end
    endcase
    cpu_rise = n.cpu_clk & ~r.cpu_clk;

    //////////////////////////////////////////////////////////////////////////
    // DMA and expansion bus clocks, both counted on processor rising edges until the processor clock is parked.

    case ({r.cpu_sel, r.dma_high})
      2'b00: dma_sel_half = `SCG_DMA_HALF_4; // R5
      2'b01: dma_sel_half = `SCG_DMA_HALF_2; // R6
      2'b10: dma_sel_half = `SCG_DMA_HALF_8; // R5
      2'b11: dma_sel_half = `SCG_DMA_HALF_4; // R6
      default: dma_sel_half = `SCG_DMA_HALF_4;
    endcase

    // Once the processor clock is parked, the DMA divider counts the ungated source instead,
    // so the DMA clock still reaches its own rising edge and parks high.
    n.src_prev = old_src;
    dma_tick = (r.cpu_st == CK_STOP) ? (old_src & ~r.src_prev) : cpu_rise; // R15

    if (cpu_rise) begin
      n.tphase = ~r.tphase;
      // A bus state spans two processor clocks; new DMA ratios take effect only
      // at its end, and no further phase alignment is attempted.
      if (r.tphase) begin
        n.dma_half = dma_sel_half; // R7
      end
      if (bus_cnt_inc >= bus_half) begin
        n.bus_cnt = 2'h0;
        n.bus_clk = ~r.bus_clk; // R9 R14
      end else begin
        n.bus_cnt = bus_cnt_inc;
      end
    end

    if (dma_tick && !r.dma_frozen) begin
      if (dma_cnt_inc >= r.dma_half) begin
        n.dma_cnt = 3'h0;
        n.dma_clk = ~r.dma_clk; // R5 R6
        if (!r.dma_clk && r.hold_seen) begin
          n.dma_frozen = 1'b1; // R14 R15
        end
      end else begin
        n.dma_cnt = dma_cnt_inc;
      end
    end

    // End of address latch restarts the bus divider phase at high speed.
    if (r.cpu_sel && !ale && r.ale_prev) begin
      n.bus_cnt = 2'h0; // R10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      r <= '0;
      r.cpu_high <= `SCG_CPU_HIGH_RST; // R21
      r.dma_high <= `SCG_DMA_HIGH_RST; // R21
      r.sleep <= `SCG_SLEEP_RST; // R21
      r.cpu_st <= CK_RUN;
      r.dma_half <= `SCG_DMA_HALF_4;
      // The synchronised request reads low for two cycles after release; the mask keeps a
      // false processor reset off the pin until the request has been seen high.
      r.reset_mask <= 1'b1;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign CPU_CLOCK_OUT = r.cpu_clk;
  assign DMA_CONTROLLER_CLOCK_OUT = r.dma_clk;
  assign EXPANSION_BUS_CLOCK_OUT = r.bus_clk;
  assign COPROCESSOR_CLOCK_OUT = r.low_src; // R8 R16
  assign CPU_RESET_OUT = r.cpu_rst;
  assign SLEEP_OUT = r.sleep;

endmodule // scg_top

// *** test/scg_top_assertions.sv ***
// Concurrent checks on the ports of the system clock generator.
`timescale 1ns/1ns

module scg_top_assertions (
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  input wire logic LOW_SPEED_OSC_IN,
  input wire logic REFERENCE_OSC_IN,
  input wire logic PORT_WR_IN,
  input wire logic [9:0] PORT_ADDR_IN,
  input wire logic [7:0] PORT_DATA_IN,
  input wire logic CPU_CLOCK_OUT,
  input wire logic DMA_CONTROLLER_CLOCK_OUT,
  input wire logic COPROCESSOR_CLOCK_OUT,
  input wire logic TIMER_CLOCK_OUT,
  input wire logic KBD_CLOCK_OUT,
  input wire logic KBD_CLOCK_N_OUT,
  input wire logic CPU_RESET_OUT,
  input wire logic SLEEP_OUT
);
  logic ref_r, tim_r, tarm_r, tchg, ref_up, set_w;
  logic [3:0] tcnt_r;
  logic [5:0] hi_r;

  assign tchg = TIMER_CLOCK_OUT != tim_r;
  assign ref_up = REFERENCE_OSC_IN && !ref_r;
  assign set_w = PORT_WR_IN && PORT_ADDR_IN == 10'h063 && PORT_DATA_IN[6];

  // The first timer half period is skipped, its window began inside reset.
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ref_r <= 1'b0;
      tim_r <= 1'b0;
      tarm_r <= 1'b0;
      tcnt_r <= 4'h0;
      hi_r <= 6'h00;
    end else begin
      ref_r <= REFERENCE_OSC_IN;
      tim_r <= TIMER_CLOCK_OUT;
      tarm_r <= tarm_r | tchg;
      tcnt_r <= tchg ? 4'(ref_up) : tcnt_r + 4'(ref_up);
      hi_r <= (CPU_CLOCK_OUT && !SLEEP_OUT) ? hi_r + 6'h01 : 6'h00;
    end
  end

  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (RST_IN);

  a_kbd_complement: assert property (KBD_CLOCK_N_OUT == !KBD_CLOCK_OUT)
    else $error("keyboard clock pair not complementary");
  a_sleep_set: assert property (set_w |=> SLEEP_OUT)
    else $error("sleep not entered after control write");
  a_sleep_keep: assert property (!SLEEP_OUT && !set_w |=> !SLEEP_OUT)
    else $error("sleep entered without control write");
  a_wake_high: assert property ($fell(SLEEP_OUT) |-> CPU_CLOCK_OUT && DMA_CONTROLLER_CLOCK_OUT)
    else $error("stopped clocks not high at wake");
  a_no_reset: assert property (SLEEP_OUT |-> !CPU_RESET_OUT)
    else $error("processor reset raised while asleep");
  a_timer_div: assert property (tchg && tarm_r |-> tcnt_r == 4'h6)
    else $error("timer half period not six reference rises");
  a_cop_follow: assert property ($rose(LOW_SPEED_OSC_IN) |-> ##[2:5] COPROCESSOR_CLOCK_OUT)
    else $error("coprocessor clock not following low source");
  a_cpu_high_lim: assert property (hi_r <= 6'h28)
    else $error("processor clock held high too long");
endmodule // scg_top_assertions

// *** test/scg_far_model.sv ***
// Oscillator sources and processor hold acknowledge seen by the clock generator.
`timescale 1ns/1ns

module scg_far_model (
  input wire logic stuck_in,
  input wire logic hold_rq_in,
  output logic low_out,
  output logic hs_out,
  output logic ref_out,
  output logic hold_acknowledge_in_out
);
  logic low_osc = 1'b0;
  logic hold_acknowledge_in_r = 1'b0;

  // Half periods are off the 40 ns grid so source edges drift through every phase of the sampling clock.
  initial forever #161 low_osc = ~low_osc;
  initial begin
    hs_out = 1'b0;
    #7;
    forever #101 hs_out = ~hs_out;
  end
  initial begin
    ref_out = 1'b0;
    #13;
    forever #141 ref_out = ~ref_out;
  end

  // With no oscillator fitted the pull-up holds the pin high.
  assign low_out = stuck_in ? 1'b1 : low_osc;
  // The processor grants hold on the first high oscillator rise after the request.
  always @(posedge hs_out) hold_acknowledge_in_r <= hold_rq_in;
  assign hold_acknowledge_in_out = hold_acknowledge_in_r;
endmodule // scg_far_model

// *** test/test_system_clock_generator.sv ***
// Self-checking bench for the system clock generator.
`timescale 1ns/1ns

module test_system_clock_generator;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_n = 1'b1;
  logic hold_rq = 1'b0;
  logic ale = 1'b0;
  logic wr = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [7:0] data = 8'h00;
  logic stuck = 1'b0;
  logic low, hs, refo, hold_acknowledge_in, cpu, dma, bus, cop, tmr, kbd, kbd_n, crst, slp;
  logic [8:0] mon;
  int fails = 0;
  int comparisons = 0;
  int cnt [9];

  assign mon = {refo, hs, low, cpu, dma, bus, cop, tmr, kbd};

  initial forever #20 clk = ~clk;

  scg_far_model FAR (.stuck_in(stuck), .hold_rq_in(hold_rq), .low_out(low), .hs_out(hs),
    .ref_out(refo), .hold_acknowledge_in_out(hold_acknowledge_in));

  scg_top DUT (.CLOCK_IN(clk), .RST_IN(rst), .LOW_SPEED_OSC_IN(low), .HIGH_SPEED_OSC_IN(hs),
    .REFERENCE_OSC_IN(refo), .CPU_RESET_REQUEST_N_IN(req_n), .HOLD_ACKNOWLEDGE_IN(hold_acknowledge_in),
    .ADDR_LATCH_EN_IN(ale), .PORT_WR_IN(wr), .PORT_ADDR_IN(addr), .PORT_DATA_IN(data),
    .CPU_CLOCK_OUT(cpu), .DMA_CONTROLLER_CLOCK_OUT(dma), .EXPANSION_BUS_CLOCK_OUT(bus),
    .COPROCESSOR_CLOCK_OUT(cop), .TIMER_CLOCK_OUT(tmr), .KBD_CLOCK_OUT(kbd),
    .KBD_CLOCK_N_OUT(kbd_n), .CPU_RESET_OUT(crst), .SLEEP_OUT(slp));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp,
    input int tol);
    comparisons++;
    if ((^seen === 1'bx) || seen + tol < exp || seen > exp + tol) begin
      fails++;
      $display("BAD %s expected %0d seen %0d", name, exp, seen);
    end
  endtask

  task automatic wrt(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    data <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Counts rising edges of sources and outputs over a window of cycles.
  task automatic measure(input int w);
    logic [8:0] prev;
    for (int i = 0; i < 9; i++) cnt[i] = 0;
    @(negedge clk);
    prev = mon;
    repeat (w) begin
      @(negedge clk);
      for (int i = 0; i < 9; i++) cnt[i] += int'(mon[i] && !prev[i]);
      prev = mon;
    end
  endtask

  // Modes run in the order 00, 01, 11, 10; the first write goes to a wrong port.
  task automatic sc_modes();
    logic [1:0] m;
    int c;
    for (int k = 0; k < 4; k++) begin
      m = 2'(k ^ (k >> 1));
      wrt(k == 0 ? 10'h062 : 10'h063, k == 0 ? 8'h43 : {6'h00, m});
      repeat (100) @(posedge clk);
      measure(2000);
      c = m[0] ? cnt[7] : cnt[6];
      chk("sleep", slp, 1'b0, 0);
      chk("cpu", cnt[5], c, 3);
      chk("dma", cnt[4], c / ((m[0] ? 8 : 4) >> m[1]), 2);
      chk("bus", cnt[3], c / (m[0] ? 4 : 2), 2);
      chk("cop", cnt[2], cnt[6], 2);
      chk("timer", cnt[1], cnt[8] / 12, 2);
      chk("kbd", cnt[0], cnt[8] / 2, 2);
      chk("kbd_n", kbd_n, !kbd, 0);
    end
  endtask

  task automatic sc_sleep();
    int n;
    logic seen_rst;
    wrt(10'h063, 8'h00);
    @(posedge clk);
    req_n <= 1'b0;
    repeat (10) @(posedge clk);
    chk("reset_req", crst, 1'b1, 0);
    req_n <= 1'b1;
    repeat (20) @(posedge clk);
    wrt(10'h063, 8'h40);
    @(negedge clk);
    chk("sleep_set", slp, 1'b1, 0);
    @(posedge clk);
    hold_rq <= 1'b1;
    repeat (100) @(posedge clk);
    measure(500);
    chk("cpu_stop", cnt[5], 0, 0);
    chk("dma_stop", cnt[4], 0, 0);
    chk("bus_stop", cnt[3], 0, 0);
    chk("cpu_level", cpu, 1'b1, 0);
    chk("dma_level", dma, 1'b1, 0);
    chk("timer_run", cnt[1], cnt[8] / 12, 2);
    chk("kbd_run", cnt[0], cnt[8] / 2, 2);
    chk("cop_run", cnt[2], cnt[6], 2);
    @(posedge clk);
    hold_rq <= 1'b0;
    req_n <= 1'b0;
    seen_rst = 1'b0;
    repeat (20) begin
      @(negedge clk);
      seen_rst |= crst;
    end
    @(posedge clk);
    req_n <= 1'b1;
    n = 0;
    while (slp !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk("no_cpu_reset", seen_rst, 1'b0, 0);
    chk("wake_delay", n, 29, 7);
    measure(1000);
    chk("cpu_restart", cnt[5], cnt[6], 3);
    chk("dma_restart", cnt[4], cnt[6] / 4, 2);
  endtask

  // At high speed a latch end just after a processor rise on which the bus did not toggle
  // restarts the bus divider, so the bus waits two more processor rises instead of one.
  task automatic sc_ale();
    int rises;
    logic cpu_was;
    logic bus_was;
    wrt(10'h063, 8'h01);
    repeat (4) begin
      @(posedge clk);
      ale <= 1'b1;
      repeat (50) @(posedge clk);
      @(negedge clk);
      cpu_was = cpu;
      bus_was = bus;
      @(negedge clk);
      while (!(cpu && !cpu_was) || bus != bus_was) begin
        cpu_was = cpu;
        bus_was = bus;
        @(negedge clk);
      end
      @(posedge clk);
      ale <= 1'b0;
      rises = 0;
      cpu_was = 1'b1;
      while (bus == bus_was && rises < 8) begin
        @(negedge clk);
        rises += int'(cpu && !cpu_was);
        cpu_was = cpu;
      end
      chk("bus_realign", rises, 2, 0);
    end
  endtask

  task automatic sc_stuck();
    @(posedge clk);
    stuck <= 1'b1;
    repeat (100) @(posedge clk);
    measure(2000);
    chk("cpu_sub", cnt[5], cnt[7] / 2, 3);
    chk("cop_sub", cnt[2], cnt[7] / 2, 3);
    @(posedge clk);
    stuck <= 1'b0;
  endtask

  // A reset in mid-run must drop sleep and return to the default speeds.
  task automatic sc_reset();
    logic seen_rst;
    wrt(10'h063, 8'h43);
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    chk("rst_sleep", slp, 1'b0, 0);
    chk("rst_kbd_n", kbd_n, 1'b1, 0);
    rst <= 1'b0;
    seen_rst = 1'b0;
    repeat (8) begin
      @(negedge clk);
      seen_rst |= crst;
    end
    chk("rst_no_pulse", seen_rst, 1'b0, 0);
    repeat (100) @(posedge clk);
    measure(1000);
    chk("rst_cpu", cnt[5], cnt[6], 3);
    chk("rst_dma", cnt[4], cnt[6] / 4, 2);
  endtask

  task automatic end_sim();
    $display("Checks %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    sc_modes();
    sc_ale();
    sc_sleep();
    sc_stuck();
    sc_reset();
    end_sim();
  end

  // The tests take about 15000 cycles; twice that means a hang.
  initial begin
    #1200000;
    fails++;
    end_sim();
  end
endmodule // test_system_clock_generator

bind scg_top scg_top_assertions CHK (.CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN),
  .LOW_SPEED_OSC_IN(LOW_SPEED_OSC_IN), .REFERENCE_OSC_IN(REFERENCE_OSC_IN),
  .PORT_WR_IN(PORT_WR_IN), .PORT_ADDR_IN(PORT_ADDR_IN), .PORT_DATA_IN(PORT_DATA_IN),
  .CPU_CLOCK_OUT(CPU_CLOCK_OUT), .DMA_CONTROLLER_CLOCK_OUT(DMA_CONTROLLER_CLOCK_OUT),
  .COPROCESSOR_CLOCK_OUT(COPROCESSOR_CLOCK_OUT), .TIMER_CLOCK_OUT(TIMER_CLOCK_OUT),
  .KBD_CLOCK_OUT(KBD_CLOCK_OUT), .KBD_CLOCK_N_OUT(KBD_CLOCK_N_OUT),
  .CPU_RESET_OUT(CPU_RESET_OUT), .SLEEP_OUT(SLEEP_OUT));
